//--- dcr_dual_clock_reset_unit.sv
`include "dcr_params.svh"
`default_nettype none
module dcr_dual_clock_reset_unit #(
  parameter int MAIN_TIMER_W = `DCR_MAIN_TIMER_W,
  parameter int SLOW_TIMER_W = `DCR_SLOW_TIMER_W,
  parameter int DIV_W = `DCR_DIV_W
) (
  // Clock and power-on reset
  input wire logic clk_sys,
  input wire logic rstn,
  // External reset pin
  input wire logic extResetN,
  // Register port
  input wire dcr_pkg::dcr_bus_req_t busReq,
  output logic [`DCR_DATA_W-1:0] regRdata,
  // Power management
  input wire logic hwWake,
  output dcr_pkg::dcr_mode_t curMode,
  output dcr_pkg::dcr_clk_status_t clkStatus,
  // Oscillators
  input wire logic slowXtalInput,
  output logic mainOscEn,
  output logic slowOscEn,
  output logic slowClkOut,
  // System reset
  output logic sysResetN
);
  import dcr_pkg::*;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic dcr_clk_ready(dcr_mode_t m, logic fastOk, logic slowOk);
    logic r;
    unique case (m)
      DCR_ACTIVE: r = fastOk;
      DCR_PSAVE, DCR_IDLE: r = slowOk;
      DCR_HALT: r = 1'b1;
    endcase
    return r;
  endfunction

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic sclk_reg;
  logic porFlag_reg;
  logic [DIV_W-1:0] slowDivisor_reg;
  logic fastOscDisable_reg;
  dcr_mode_t curMode_reg;
  dcr_mode_t tgtMode_reg;
  logic pending_reg;
  logic [DIV_W-1:0] divCnt_reg;
  logic slowDiv_reg;
  logic slowClk_reg;
  logic xtalSync1_reg;
  logic xtalSync2_reg;
  logic xtalPrev_reg;
  logic fastGoodFlag_reg;
  logic slowGoodFlag_reg;
  logic porDone_reg;
  logic sysResetN_reg;
  logic [`DCR_DATA_W-1:0] regRdata_reg;
  logic [`DCR_DATA_W-1:0] rdMux;
  logic [MAIN_TIMER_W-1:0] mainCnt;
  logic [SLOW_TIMER_W-1:0] slowCnt;
  logic mainDone;
  logic slowDone;
  logic stopMain;
  logic stopSlow;
  logic mainGood;
  logic lsGood;
  logic slowSelEff;
  logic wakeActive;
  logic xtalToggle;
  logic wrCtrl;
  logic wrPre;
  logic wrPm;
  dcr_mode_t swMode;

  assign wrCtrl = busReq.wr && busReq.addr == `DCR_OFS_CTRL;
  assign wrPre = busReq.wr && busReq.addr == `DCR_OFS_PRESCALE;
  assign wrPm = busReq.wr && busReq.addr == `DCR_OFS_PMCTRL;
  assign swMode = dcr_mode_t'(busReq.wdata[`DCR_PM_MODE_LSB +: 2]);

  // ---------------------------------------------------------------
  // Slow crystal input synchroniser and toggle detect
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      xtalSync1_reg <= 1'b0;
      xtalSync2_reg <= 1'b0;
      xtalPrev_reg <= 1'b0;
    end else begin
      xtalSync1_reg <= slowXtalInput;
      xtalSync2_reg <= xtalSync1_reg;
      xtalPrev_reg <= xtalSync2_reg;
    end
  end

  assign xtalToggle = xtalSync2_reg ^ xtalPrev_reg;

  // ---------------------------------------------------------------
  // Oscillator stop requests
  // ---------------------------------------------------------------
  assign wakeActive = pending_reg && tgtMode_reg == DCR_ACTIVE;
  // Main clock may stop only in Halt, or in Power Save / Idle when the
  // slow crystal really drives the slow clock and software disabled it
  assign stopMain = !wakeActive && (curMode_reg == DCR_HALT ||
                    (slowSelEff && fastOscDisable_reg &&
                     (curMode_reg == DCR_PSAVE || curMode_reg == DCR_IDLE)));
  assign stopSlow = !wakeActive && curMode_reg == DCR_HALT;
  assign mainOscEn = !stopMain;
  assign slowOscEn = !stopSlow;

  // ---------------------------------------------------------------
  // Stabilisation timers
  // ---------------------------------------------------------------
  dcr_stab_timer #(.W(MAIN_TIMER_W)) uMainTimer (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .load(stopMain),
    .tick(1'b1),
    .count(mainCnt),
    .done(mainDone)
  );

  dcr_stab_timer #(.W(SLOW_TIMER_W)) uSlowTimer (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .load(stopSlow),
    .tick(xtalToggle),
    .count(slowCnt),
    .done(slowDone)
  );

  assign mainGood = mainDone && !stopMain;
  assign lsGood = slowDone && !stopSlow;
  // Crystal counts as present only once its toggles ran the timer out
  assign slowSelEff = sclk_reg && lsGood;

  // ---------------------------------------------------------------
  // Status flags
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      fastGoodFlag_reg <= 1'b0;
      slowGoodFlag_reg <= 1'b0;
    end else begin
      fastGoodFlag_reg <= mainGood;
      slowGoodFlag_reg <= slowSelEff ? lsGood : mainGood;
    end
  end

  // ---------------------------------------------------------------
  // Power-on and external reset
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      porDone_reg <= 1'b0;
      sysResetN_reg <= 1'b0;
    end else begin
      if (mainDone) begin
        porDone_reg <= 1'b1;
      end
      sysResetN_reg <= porDone_reg && extResetN;
    end
  end

  assign sysResetN = sysResetN_reg;

  // ---------------------------------------------------------------
  // Control register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sclk_reg <= 1'b0;
      porFlag_reg <= 1'b1;
    end else if (wrCtrl) begin
      sclk_reg <= busReq.wdata[`DCR_CTRL_SCLK_BIT];
      if (!busReq.wdata[`DCR_CTRL_POR_BIT]) begin
        porFlag_reg <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Prescaler register and divider
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      slowDivisor_reg <= DIV_W'(`DCR_DIV_RESET);
    end else if (wrPre) begin
      slowDivisor_reg <= busReq.wdata[DIV_W-1:0];
    end
  end

  // Half period is divisor+1 cycles, so ratio is 2*(divisor+1)
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      divCnt_reg <= '0;
      slowDiv_reg <= 1'b0;
    end else if (slowSelEff) begin
      divCnt_reg <= '0;
    end else if (divCnt_reg >= slowDivisor_reg) begin
      divCnt_reg <= '0;
      slowDiv_reg <= !slowDiv_reg;
    end else begin
      divCnt_reg <= divCnt_reg + 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      slowClk_reg <= 1'b0;
    end else begin
      slowClk_reg <= slowSelEff ? xtalSync2_reg : slowDiv_reg;
    end
  end

  assign slowClkOut = slowClk_reg;

  // ---------------------------------------------------------------
  // Power mode switching
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      fastOscDisable_reg <= 1'b0;
    end else if (hwWake) begin
      fastOscDisable_reg <= 1'b0;
    end else if (wrPm) begin
      fastOscDisable_reg <= busReq.wdata[`DCR_PM_DHF_BIT];
    end
  end

  // A request is held pending until the clock that mode needs is good
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      curMode_reg <= DCR_ACTIVE;
      tgtMode_reg <= DCR_ACTIVE;
      pending_reg <= 1'b0;
    end else if (hwWake && curMode_reg != DCR_ACTIVE) begin
      tgtMode_reg <= DCR_ACTIVE;
      pending_reg <= 1'b1;
    end else if (wrPm) begin
      tgtMode_reg <= swMode;
      pending_reg <= 1'b1;
    end else if (pending_reg &&
                 dcr_clk_ready(tgtMode_reg, fastGoodFlag_reg, slowGoodFlag_reg)) begin
      curMode_reg <= tgtMode_reg;
      pending_reg <= 1'b0;
    end
  end

  assign curMode = curMode_reg;
  assign clkStatus = '{slowSelEff: slowSelEff, xtalPresent: lsGood,
                       slowGood: slowGoodFlag_reg, fastGood: fastGoodFlag_reg};

  // ---------------------------------------------------------------
  // Register read
  // ---------------------------------------------------------------
  always_comb begin
    rdMux = '0;
    unique case (busReq.addr)
      `DCR_OFS_CTRL: begin
        rdMux[`DCR_CTRL_SCLK_BIT] = sclk_reg;
        rdMux[`DCR_CTRL_POR_BIT] = porFlag_reg;
      end
      `DCR_OFS_PRESCALE: rdMux[DIV_W-1:0] = slowDivisor_reg;
      `DCR_OFS_STATUS: begin
        rdMux[`DCR_ST_FAST_BIT] = fastGoodFlag_reg;
        rdMux[`DCR_ST_SLOW_BIT] = slowGoodFlag_reg;
        rdMux[`DCR_ST_XTAL_BIT] = lsGood;
        rdMux[`DCR_ST_SEL_BIT] = slowSelEff;
      end
      `DCR_OFS_PMCTRL: begin
        rdMux[`DCR_PM_MODE_LSB +: 2] = curMode_reg;
        rdMux[`DCR_PM_DHF_BIT] = fastOscDisable_reg;
        rdMux[`DCR_PM_PEND_BIT] = pending_reg;
      end
      default: rdMux = '0;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      regRdata_reg <= '0;
    end else begin
      regRdata_reg <= busReq.rd ? rdMux : '0;
    end
  end

  assign regRdata = regRdata_reg;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  property p_mode_gate;
    $changed(curMode_reg) |->
      dcr_clk_ready(curMode_reg, $past(fastGoodFlag_reg), $past(slowGoodFlag_reg));
  endproperty
  a_mode_gate: assert property (p_mode_gate)
    else $error("mode changed before its clock was good");

  property p_fast_flag;
    stopMain |=> !fastGoodFlag_reg;
  endproperty
  a_fast_flag: assert property (p_fast_flag)
    else $error("fast good flag set while main oscillator stopped");

  property p_no_xtal_run;
    !slowSelEff && curMode_reg != DCR_HALT |-> mainOscEn;
  endproperty
  a_no_xtal_run: assert property (p_no_xtal_run)
    else $error("main oscillator stopped without slow crystal");

  property p_main_count;
    $rose(mainGood) && !$past(stopMain) |-> $past(mainCnt) == MAIN_TIMER_W'(1);
  endproperty
  a_main_count: assert property (p_main_count)
    else $error("main good rose before countdown end");

  property p_main_preset;
    stopMain |=> mainCnt == {MAIN_TIMER_W{1'b1}} && !mainGood;
  endproperty
  a_main_preset: assert property (p_main_preset)
    else $error("main timer not preset by stop request");

  property p_slow_preset;
    stopSlow |=> slowCnt == {SLOW_TIMER_W{1'b1}};
  endproperty
  a_slow_preset: assert property (p_slow_preset)
    else $error("slow timer not preset by stop request");

  property p_div_period;
    $changed(slowDiv_reg) |-> $past(divCnt_reg) >= $past(slowDivisor_reg);
  endproperty
  a_div_period: assert property (p_div_period)
    else $error("divider toggled before reaching divisor");

  property p_sel_needs_xtal;
    slowSelEff |-> sclk_reg && slowDone;
  endproperty
  a_sel_needs_xtal: assert property (p_sel_needs_xtal)
    else $error("slow crystal selected without toggling");

  property p_por_hold;
    !porDone_reg |=> !sysResetN_reg;
  endproperty
  a_por_hold: assert property (p_por_hold)
    else $error("reset released before power-up countdown");

  property p_ext_reset;
    !extResetN |=> !sysResetN_reg;
  endproperty
  a_ext_reset: assert property (p_ext_reset)
    else $error("external reset did not hold internal reset");

  property p_por_flag;
    !porFlag_reg |=> !porFlag_reg;
  endproperty
  a_por_flag: assert property (p_por_flag)
    else $error("power-up flag set by software");

  property p_slow_flag;
    ##1 slowGoodFlag_reg == $past(slowSelEff ? lsGood : mainGood);
  endproperty
  a_slow_flag: assert property (p_slow_flag)
    else $error("slow good flag not the sampled selection");

  property p_wake;
    hwWake && curMode_reg != DCR_ACTIVE |=>
      !fastOscDisable_reg && pending_reg && tgtMode_reg == DCR_ACTIVE;
  endproperty
  a_wake: assert property (p_wake)
    else $error("wake did not clear disable and request active");

endmodule
`default_nettype wire

//--- dcr_params.svh
`ifndef DCR_PARAMS_SVH
`define DCR_PARAMS_SVH

// Register offsets
`define DCR_OFS_CTRL 4'h0
`define DCR_OFS_PRESCALE 4'h1
`define DCR_OFS_STATUS 4'h2
`define DCR_OFS_PMCTRL 4'h3

// Field positions
`define DCR_CTRL_SCLK_BIT 0
`define DCR_CTRL_POR_BIT 1
`define DCR_PM_MODE_LSB 0
`define DCR_PM_DHF_BIT 2
`define DCR_PM_PEND_BIT 3
`define DCR_ST_FAST_BIT 0
`define DCR_ST_SLOW_BIT 1
`define DCR_ST_XTAL_BIT 2
`define DCR_ST_SEL_BIT 3

// Widths and reset values
`define DCR_ADDR_W 4
`define DCR_DATA_W 8
`define DCR_MAIN_TIMER_W 14
`define DCR_SLOW_TIMER_W 6
`define DCR_DIV_W 8
`define DCR_DIV_RESET 8'hff

`endif

//--- dcr_pkg.sv
`include "dcr_params.svh"
`default_nettype none
package dcr_pkg;

  typedef enum logic [1:0] {
    DCR_ACTIVE = 2'b00,
    DCR_PSAVE = 2'b01,
    DCR_IDLE = 2'b10,
    DCR_HALT = 2'b11
  } dcr_mode_t;

  typedef struct packed {
    logic [`DCR_ADDR_W-1:0] addr;
    logic [`DCR_DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } dcr_bus_req_t;

  typedef struct packed {
    logic slowSelEff;
    logic xtalPresent;
    logic slowGood;
    logic fastGood;
  } dcr_clk_status_t;

endpackage
`default_nettype wire

//--- dcr_stab_timer.sv
`default_nettype none
module dcr_stab_timer #(
  parameter int W = 6
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Control
  input wire logic load,
  input wire logic tick,
  // Status
  output logic [W-1:0] count,
  output logic done
);
  logic [W-1:0] count_reg;

  // ---------------------------------------------------------------
  // Down-counter: preset to all ones, stops at zero
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      count_reg <= '1;
    end else if (load) begin
      count_reg <= '1;
    end else if (tick && count_reg != '0) begin
      count_reg <= count_reg - 1'b1;
    end
  end

  assign count = count_reg;
  assign done = (count_reg == '0);
endmodule
`default_nettype wire

//--- dcr_osc_model.sv
`default_nettype none
module dcr_osc_model #(
  parameter int HALF = 3
) (
  // Clock
  input wire logic clk_sys,
  // Crystal fitted and enable
  input wire logic xtalFitted,
  input wire logic slowOscEn,
  // Crystal pin
  output logic slowXtalInput
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  initial slowXtalInput = 1'b0;
  // -------------------------------------------------
  // Slow crystal: runs only while fitted and enabled
  // -------------------------------------------------
  // An absent or stopped crystal leaves the pin tied low
  always @(posedge clk_sys) begin
    if (!(xtalFitted && slowOscEn)) begin
      slowXtalInput <= 1'b0;
      cnt <= 0;
    end else if (cnt == HALF - 1) begin
      slowXtalInput <= ~slowXtalInput;
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule
`default_nettype wire

//--- dual_clock_reset_control_tb_top.sv
`default_nettype none
module dual_clock_reset_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import dcr_pkg::*;
  logic clk_sys, rstn, extResetN, hwWake, slowXtalInput, xtalFitted, rdLast;
  logic mainOscEn, slowOscEn, slowClkOut, sysResetN;
  logic [7:0] regRdata;
  logic [7:0] expQ[$];
  dcr_bus_req_t busReq;
  dcr_mode_t curMode;
  dcr_clk_status_t clkStatus;
  int err_count = 0;
  int cmp_count = 0;
  int n;
  int d;

  dcr_dual_clock_reset_unit #(.MAIN_TIMER_W(4), .SLOW_TIMER_W(3), .DIV_W(8)) DUT (
    .clk_sys(clk_sys), .rstn(rstn), .extResetN(extResetN), .busReq(busReq),
    .regRdata(regRdata), .hwWake(hwWake), .curMode(curMode), .clkStatus(clkStatus),
    .slowXtalInput(slowXtalInput), .mainOscEn(mainOscEn), .slowOscEn(slowOscEn),
    .slowClkOut(slowClkOut), .sysResetN(sysResetN));

  dcr_osc_model #(.HALF(3)) osc (.clk_sys(clk_sys), .xtalFitted(xtalFitted),
    .slowOscEn(slowOscEn), .slowXtalInput(slowXtalInput));

  initial clk_sys = 1'b0;
  always #5 clk_sys = ~clk_sys;

  // -------------------------------------------------
  // Compare and closing tasks
  // -------------------------------------------------
  task automatic chk_rd(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t read got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_sig(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t signal got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic close_out;
    if (err_count == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // -------------------------------------------------
  // Register port master
  // -------------------------------------------------
  task automatic bus(input logic [3:0] a, input logic [7:0] dat, input logic w);
    @(posedge clk_sys);
    busReq <= '{addr: a, wdata: dat, wr: w, rd: !w};
    @(posedge clk_sys);
    busReq <= '0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    expQ.push_back(e);
    bus(a, 8'h00, 1'b0);
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask

  task automatic half_period(input int exp);
    int k;
    logic prev;
    for (k = 0; k < 3; k++) begin
      prev = slowClkOut;
      n = 0;
      do begin
        @(negedge clk_sys);
        n++;
      end while (slowClkOut === prev && n < 600);
    end
    chk_sig(8'(n - 1), 8'(exp - 1));
  endtask

  // Read data stand one cycle after the strobe, otherwise zero
  always @(negedge clk_sys) begin
    if (rdLast && expQ.size() > 0) chk_rd(regRdata, expQ.pop_front());
    else chk_rd(regRdata, 8'h00);
    rdLast = busReq.rd;
  end

  initial begin
    #200000;
    err_count++;
    close_out();
  end

  // -------------------------------------------------
  // Main sequence
  // -------------------------------------------------
  initial begin
    rstn = 1'b0;
    extResetN = 1'b1;
    hwWake = 1'b0;
    xtalFitted = 1'b0;
    busReq = '0;
    rdLast = 1'b0;
    d = $urandom(34);
    repeat (12) @(posedge clk_sys);
    rstn <= 1'b1;
    n = 0;
    while (sysResetN !== 1'b1 && n < 60) begin
      @(negedge clk_sys);
      n++;
    end
    chk_sig(8'(n >= 15 && n <= 20), 8'h01);
    rd(4'h0, 8'h02);
    rd(4'h1, 8'hff);
    rd(4'h2, 8'h03);
    rd(4'h4, 8'h00);
    bus(4'h0, 8'h02, 1'b1);
    rd(4'h0, 8'h02);
    bus(4'h0, 8'h00, 1'b1);
    rd(4'h0, 8'h00);
    bus(4'h2, 8'hff, 1'b1);
    rd(4'h2, 8'h03);
    for (int i = 0; i < 3; i++) begin
      d = (i == 0) ? 0 : (i == 1) ? ($urandom % 6) + 1 : 255;
      bus(4'h1, 8'(d), 1'b1);
      rd(4'h1, 8'(d));
      half_period(d + 1);
    end
    // Without a slow crystal the fast oscillator ignores the disable
    bus(4'h3, 8'h05, 1'b1);
    cyc(4);
    chk_sig(8'(curMode), 8'h01);
    chk_sig(8'(mainOscEn), 8'h01);
    bus(4'h3, 8'h03, 1'b1);
    cyc(4);
    chk_sig(8'(curMode), 8'h03);
    chk_sig(8'(mainOscEn), 8'h00);
    chk_sig(8'(slowOscEn), 8'h00);
    @(posedge clk_sys);
    hwWake <= 1'b1;
    @(posedge clk_sys);
    hwWake <= 1'b0;
    n = 0;
    while (curMode !== DCR_ACTIVE && n < 100) begin
      @(negedge clk_sys);
      n++;
      if (n == 3) begin
        chk_sig(8'(clkStatus.fastGood), 8'h00);
        chk_sig(8'(mainOscEn), 8'h01);
      end
    end
    chk_sig(8'(n >= 15 && n <= 20), 8'h01);
    // Crystal fitted: select takes effect only once it toggles
    xtalFitted <= 1'b1;
    bus(4'h0, 8'h01, 1'b1);
    rd(4'h2, 8'h03);
    cyc(60);
    rd(4'h2, 8'h0f);
    bus(4'h3, 8'h05, 1'b1);
    cyc(4);
    chk_sig(8'(curMode), 8'h01);
    chk_sig(8'(mainOscEn), 8'h00);
    bus(4'h3, 8'h00, 1'b1);
    cyc(4);
    chk_sig(8'(curMode), 8'h01);
    chk_sig(8'(clkStatus.fastGood), 8'h00);
    cyc(20);
    chk_sig(8'(curMode), 8'h00);
    // Idle with the crystal in use, then a wake back to Active
    bus(4'h3, 8'h02, 1'b1);
    cyc(4);
    chk_sig(8'(curMode), 8'h02);
    chk_sig(8'(mainOscEn), 8'h01);
    @(posedge clk_sys);
    hwWake <= 1'b1;
    @(posedge clk_sys);
    hwWake <= 1'b0;
    cyc(2);
    chk_sig(8'(curMode), 8'h00);
    // External reset holds the internal reset for as long as it is low
    @(posedge clk_sys);
    extResetN <= 1'b0;
    cyc(3);
    chk_sig(8'(sysResetN), 8'h00);
    cyc(20);
    chk_sig(8'(sysResetN), 8'h00);
    @(posedge clk_sys);
    extResetN <= 1'b1;
    cyc(3);
    chk_sig(8'(sysResetN), 8'h01);
    close_out();
  end
endmodule
`default_nettype wire
